// file: rtl/tmr_cfg.svh
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ----------------------------------------------------------------
// Register addresses on the internal I/O bus
// ----------------------------------------------------------------
`define TMR_A_T0_CMP_B   6'h17
`define TMR_A_T0_CMP_A   6'h18
`define TMR_A_T0_CNT     6'h19
`define TMR_A_T0_CTRL_B  6'h1a
`define TMR_A_T0_CTRL_A  6'h1b
`define TMR_A_W_CAP_L    6'h26
`define TMR_A_W_CAP_H    6'h27
`define TMR_A_W_CMPB_L   6'h28
`define TMR_A_W_CMPB_H   6'h29
`define TMR_A_W_CMPA_L   6'h2a
`define TMR_A_W_CMPA_H   6'h2b
`define TMR_A_W_CNT_L    6'h2c
`define TMR_A_W_CNT_H    6'h2d
`define TMR_A_W_CTRL_B   6'h2e
`define TMR_A_W_CTRL_A   6'h2f
`define TMR_A_FLAGS      6'h39
`define TMR_A_MASK       6'h3a

// ----------------------------------------------------------------
// Flag and mask bit positions (mask differs on the wide compares)
// ----------------------------------------------------------------
`define TMR_B_T0_CMPA    0
`define TMR_B_T0_OVF     1
`define TMR_B_T0_CMPB    2
`define TMR_B_W_CAP      3
`define TMR_B_W_CMPA     5
`define TMR_B_W_CMPB     6
`define TMR_M_W_CMPB     5
`define TMR_M_W_CMPA     6
`define TMR_B_W_OVF      7
`define TMR_FLAGS_USED   8'hef

// ----------------------------------------------------------------
// Control field positions and writable masks
// ----------------------------------------------------------------
`define TMR_B_T0_MODE2   3
`define TMR_B_W_NOISE    7
`define TMR_B_W_EDGE     6
`define TMR_T0_CTRL_B_WR 8'h0f
`define TMR_W_CTRL_A_WR  8'hf3
`define TMR_W_CTRL_B_WR  8'hdf

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TMR_RST_BYTE     8'h00
`define TMR_RST_WORD     16'h0000

// ----------------------------------------------------------------
// Counter limits and fixed tops
// ----------------------------------------------------------------
`define TMR_T0_MAX       8'hff
`define TMR_W_BOTTOM     16'h0000
`define TMR_W_MAX        16'hffff
`define TMR_W_TOP8       16'h00ff
`define TMR_W_TOP9       16'h01ff
`define TMR_W_TOP10      16'h03ff

// ----------------------------------------------------------------
// Prescaler taps (low bits that must be zero) and filter depth
// ----------------------------------------------------------------
`define TMR_PSC_W        10
`define TMR_TAP_DIV8     3
`define TMR_TAP_DIV64    6
`define TMR_TAP_DIV256   8
`define TMR_TAP_DIV1024  10
`define TMR_NC_DEPTH     4

`endif

// file: rtl/tmr_pkg.sv
`include "tmr_cfg.svh"

package tmr_pkg;

   typedef enum logic [1:0] {
      SL_NORMAL,
      SL_CTC,
      SL_FAST,
      SL_DUAL
   } tmr_slope_e;

   typedef enum logic [2:0] {
      TS_MAX,
      TS_8BIT,
      TS_9BIT,
      TS_10BIT,
      TS_CMPA,
      TS_CAP
   } tmr_top_e;

   typedef struct packed {
      logic [7:0]                flags;
      logic [7:0]                mask;
      logic [7:0]                t0_ctrl_a;
      logic [7:0]                t0_ctrl_b;
      logic [7:0]                t0_cmp_a;
      logic [7:0]                t0_cmp_b;
      logic [7:0]                w_ctrl_a;
      logic [7:0]                w_ctrl_b;
      logic [7:0]                temp;
      logic [7:0]                rdata;
      logic [15:0]               w_cmp_a_buf;
      logic [15:0]               w_cmp_b_buf;
      logic [15:0]               w_cmp_a;
      logic [15:0]               w_cmp_b;
      logic [15:0]               w_capture;
      logic [`TMR_PSC_W-1:0]     psc;
      logic                      t0_pin_prev;
      logic                      w_pin_prev;
      logic [`TMR_NC_DEPTH-1:0]  cap_pipe;
      logic                      cap_level;
      logic                      cap_prev;
      logic                      wave_a;
      logic                      wave_b;
   } tmr_state_s;

   function automatic logic clk_sel(input logic [2:0]            cs,
                                    input logic [`TMR_PSC_W-1:0] p,
                                    input logic                  pin,
                                    input logic                  prev);
      logic r;
      case (cs)
         3'h0:    r = 1'b0;
         3'h1:    r = 1'b1;
         3'h2:    r = (p[`TMR_TAP_DIV8-1:0] == '0);
         3'h3:    r = (p[`TMR_TAP_DIV64-1:0] == '0);
         3'h4:    r = (p[`TMR_TAP_DIV256-1:0] == '0);
         3'h5:    r = (p[`TMR_TAP_DIV1024-1:0] == '0);
         3'h6:    r = prev & ~pin;
         default: r = ~prev & pin;
      endcase
      return r;
   endfunction

   function automatic logic wave_next(input logic       cur,
                                      input logic [1:0] com,
                                      input tmr_slope_e sl,
                                      input logic       match,
                                      input logic       wrap,
                                      input logic       down,
                                      input logic       is_top);
      logic r;
      r = cur;
      if (sl == SL_NORMAL || sl == SL_CTC) begin
         if (match) begin
            case (com)
               2'h1:    r = ~cur;
               2'h2:    r = 1'b0;
               2'h3:    r = 1'b1;
               default: r = cur;
            endcase
         end
      end else if (is_top) begin
         if (match && com == 2'h1) begin
            r = ~cur;
         end
      end else if (sl == SL_FAST) begin
         if (match && com[1]) begin
            r = com[0];
         end else if (wrap && com[1]) begin
            r = ~com[0];
         end
      end else if (match && com[1]) begin
         r = com[0] ^ down;
      end
      return r;
   endfunction

endpackage

// file: rtl/tmr_count_unit.sv
`timescale 1ns/1ps

module tmr_count_unit #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         tick,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic [W-1:0] top,
   input  wire logic         dual,
   output logic      [W-1:0] count,
   output logic              down
);

   typedef struct packed {
      logic [W-1:0] count;
      logic         down;
   } tmr_cnt_s;

   tmr_cnt_s s_q;
   tmr_cnt_s s_d;

   if (W < 2) begin : g_bad_width
      $error("tmr_count_unit: W must be at least 2");
   end

   // ----------------------------------------------------------------
   // Next count
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (load) begin
         s_d.count = load_value;
      end else if (tick) begin
         if (!dual) begin
            s_d.down  = 1'b0;
            s_d.count = (s_q.count == top) ? '0 : s_q.count + 1'b1;
         end else if (!s_q.down) begin
            if (s_q.count >= top) begin
               s_d.down  = 1'b1;
               s_d.count = s_q.count - 1'b1;
            end else begin
               s_d.count = s_q.count + 1'b1;
            end
         end else if (s_q.count == '0) begin
            s_d.down  = 1'b0;
            s_d.count = s_q.count + 1'b1;
         end else begin
            s_d.count = s_q.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.count;
   assign down  = s_q.down;

endmodule

// file: rtl/tmr_core.sv
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_core #(
   parameter int WIDE_W = 16,
   parameter int T0_W   = 8
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   input  wire logic       global_irq_en,
   input  wire logic [7:0] vector_taken,
   output logic      [7:0] irq_req,
   input  wire logic       t0_ext_clock_pin,
   input  wire logic       wide_ext_clock_pin,
   input  wire logic       wide_capture_pin,
   input  wire logic       acmp_out,
   input  wire logic       acmp_capture_sel,
   output logic            wide_wave_out_a,
   output logic            wide_wave_out_b
);

   if (WIDE_W != 16 || T0_W != 8) begin : g_bad_width
      $error("tmr_core: byte access logic serves only 16-bit and 8-bit counters");
   end

   tmr_pkg::tmr_state_s s_q;
   tmr_pkg::tmr_state_s s_d;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic tmr_pkg::tmr_slope_e wide_slope(input logic [3:0] m);
      tmr_pkg::tmr_slope_e r;
      case (m)
         4'h4, 4'hc:                        r = tmr_pkg::SL_CTC;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf:      r = tmr_pkg::SL_FAST;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
         4'ha, 4'hb:                        r = tmr_pkg::SL_DUAL;
         default:                           r = tmr_pkg::SL_NORMAL;
      endcase
      return r;
   endfunction

   function automatic tmr_pkg::tmr_top_e wide_top_sel(input logic [3:0] m);
      tmr_pkg::tmr_top_e r;
      case (m)
         4'h1, 4'h5:                r = tmr_pkg::TS_8BIT;
         4'h2, 4'h6:                r = tmr_pkg::TS_9BIT;
         4'h3, 4'h7:                r = tmr_pkg::TS_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf:    r = tmr_pkg::TS_CMPA;
         4'h8, 4'ha, 4'hc, 4'he:    r = tmr_pkg::TS_CAP;
         default:                   r = tmr_pkg::TS_MAX;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Timer0 counter
   // ----------------------------------------------------------------
   logic [2:0] t0_mode;
   logic       t0_tick;
   logic       t0_dual;
   logic [7:0] t0_top;
   logic [7:0] t0_count;
   logic       t0_down;
   logic       t0_ovf_ev;
   logic       t0_ma;
   logic       t0_mb;

   assign t0_mode = {s_q.t0_ctrl_b[`TMR_B_T0_MODE2], s_q.t0_ctrl_a[1:0]};
   assign t0_tick = tmr_pkg::clk_sel(s_q.t0_ctrl_b[2:0], s_q.psc,
                                     t0_ext_clock_pin, s_q.t0_pin_prev);
   assign t0_dual = (t0_mode == 3'h1) || (t0_mode == 3'h5);
   assign t0_top  = (t0_mode == 3'h2 || t0_mode == 3'h5 || t0_mode == 3'h7) ?
                    s_q.t0_cmp_a : `TMR_T0_MAX;

   tmr_count_unit #(.W(T0_W)) u_t0_count (
      .clk        (clk),
      .rst        (rst),
      .tick       (t0_tick),
      .load       (io_wr && io_addr == `TMR_A_T0_CNT),
      .load_value (io_wdata),
      .top        (t0_top),
      .dual       (t0_dual),
      .count      (t0_count),
      .down       (t0_down)
   );

   always_comb begin
      if (t0_dual) begin
         t0_ovf_ev = t0_tick && t0_down && t0_count == '0;
      end else if (t0_mode == 3'h7) begin
         t0_ovf_ev = t0_tick && t0_count == t0_top;
      end else begin
         t0_ovf_ev = t0_tick && t0_count == `TMR_T0_MAX;
      end
   end

   assign t0_ma = t0_tick && t0_count == s_q.t0_cmp_a;
   assign t0_mb = t0_tick && t0_count == s_q.t0_cmp_b;

   // ----------------------------------------------------------------
   // Wide counter
   // ----------------------------------------------------------------
   logic [3:0]          w_mode;
   tmr_pkg::tmr_slope_e w_slope;
   tmr_pkg::tmr_top_e   w_top_sel;
   logic [15:0]         w_top;
   logic                w_tick;
   logic [15:0]         w_count;
   logic                w_down;
   logic                w_top_ev;
   logic                w_ovf_ev;
   logic                w_ma;
   logic                w_mb;
   logic                w_pwm;
   logic                cap_src;
   logic                cap_edge;

   assign w_mode    = {s_q.w_ctrl_b[4:3], s_q.w_ctrl_a[1:0]};
   assign w_slope   = wide_slope(w_mode);
   assign w_top_sel = wide_top_sel(w_mode);
   assign w_tick    = tmr_pkg::clk_sel(s_q.w_ctrl_b[2:0], s_q.psc,
                                       wide_ext_clock_pin, s_q.w_pin_prev);
   assign w_pwm     = (w_slope == tmr_pkg::SL_FAST) || (w_slope == tmr_pkg::SL_DUAL);

   always_comb begin
      case (w_top_sel)
         tmr_pkg::TS_8BIT:  w_top = `TMR_W_TOP8;
         tmr_pkg::TS_9BIT:  w_top = `TMR_W_TOP9;
         tmr_pkg::TS_10BIT: w_top = `TMR_W_TOP10;
         tmr_pkg::TS_CMPA:  w_top = s_q.w_cmp_a;
         tmr_pkg::TS_CAP:   w_top = s_q.w_capture;
         default:           w_top = `TMR_W_MAX;
      endcase
   end

   tmr_count_unit #(.W(WIDE_W)) u_w_count (
      .clk        (clk),
      .rst        (rst),
      .tick       (w_tick),
      .load       (io_wr && io_addr == `TMR_A_W_CNT_L),
      .load_value ({s_q.temp, io_wdata}),
      .top        (w_top),
      .dual       (w_slope == tmr_pkg::SL_DUAL),
      .count      (w_count),
      .down       (w_down)
   );

   assign w_top_ev = w_tick && w_count == w_top;
   assign w_ma     = w_tick && w_count == s_q.w_cmp_a;
   assign w_mb     = w_tick && w_count == s_q.w_cmp_b;

   always_comb begin
      case (w_slope)
         tmr_pkg::SL_FAST: w_ovf_ev = w_top_ev;
         tmr_pkg::SL_DUAL: w_ovf_ev = w_tick && w_down && w_count == `TMR_W_BOTTOM;
         default:          w_ovf_ev = w_tick && w_count == `TMR_W_MAX;
      endcase
   end

   // Capture input disabled while the capture register defines top
   assign cap_src  = acmp_capture_sel ? acmp_out : wide_capture_pin;
   assign cap_edge = (w_top_sel != tmr_pkg::TS_CAP) && (s_q.cap_level != s_q.cap_prev) &&
                     (s_q.cap_level == s_q.w_ctrl_b[`TMR_B_W_EDGE]);

   // ----------------------------------------------------------------
   // Register file, flags and waveform state
   // ----------------------------------------------------------------
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] mask_by_flag;

   always_comb begin
      s_d             = s_q;
      s_d.psc         = s_q.psc + 1'b1;
      s_d.t0_pin_prev = t0_ext_clock_pin;
      s_d.w_pin_prev  = wide_ext_clock_pin;

      // Capture filter and edge history
      s_d.cap_pipe = {s_q.cap_pipe[`TMR_NC_DEPTH-2:0], cap_src};
      s_d.cap_prev = s_q.cap_level;
      if (!s_q.w_ctrl_b[`TMR_B_W_NOISE]) begin
         s_d.cap_level = cap_src;
      end else if (s_q.cap_pipe == '0 || s_q.cap_pipe == '1) begin
         s_d.cap_level = s_q.cap_pipe[`TMR_NC_DEPTH-1];
      end
      if (cap_edge) begin
         s_d.w_capture = w_count;
      end

      // Bus writes
      if (io_wr) begin
         case (io_addr)
            `TMR_A_MASK:      s_d.mask      = io_wdata & `TMR_FLAGS_USED;
            `TMR_A_T0_CTRL_A: s_d.t0_ctrl_a = io_wdata;
            `TMR_A_T0_CTRL_B: s_d.t0_ctrl_b = io_wdata & `TMR_T0_CTRL_B_WR;
            `TMR_A_T0_CMP_A:  s_d.t0_cmp_a  = io_wdata;
            `TMR_A_T0_CMP_B:  s_d.t0_cmp_b  = io_wdata;
            `TMR_A_W_CTRL_A:  s_d.w_ctrl_a  = io_wdata & `TMR_W_CTRL_A_WR;
            `TMR_A_W_CTRL_B:  s_d.w_ctrl_b  = io_wdata & `TMR_W_CTRL_B_WR;
            `TMR_A_W_CNT_H,
            `TMR_A_W_CMPA_H,
            `TMR_A_W_CMPB_H,
            `TMR_A_W_CAP_H:   s_d.temp      = io_wdata;
            `TMR_A_W_CMPA_L:  s_d.w_cmp_a_buf = {s_q.temp, io_wdata};
            `TMR_A_W_CMPB_L:  s_d.w_cmp_b_buf = {s_q.temp, io_wdata};
            `TMR_A_W_CAP_L: begin
               if (w_top_sel == tmr_pkg::TS_CAP) begin
                  s_d.w_capture = {s_q.temp, io_wdata};
               end
            end
            default: ;
         endcase
      end

      // Compare buffers: immediate outside PWM, at top inside PWM
      if (!w_pwm || w_top_ev) begin
         s_d.w_cmp_a = s_d.w_cmp_a_buf;
         s_d.w_cmp_b = s_d.w_cmp_b_buf;
      end

      // Bus reads
      if (io_rd) begin
         case (io_addr)
            `TMR_A_FLAGS:     s_d.rdata = s_q.flags;
            `TMR_A_MASK:      s_d.rdata = s_q.mask;
            `TMR_A_T0_CTRL_A: s_d.rdata = s_q.t0_ctrl_a;
            `TMR_A_T0_CTRL_B: s_d.rdata = s_q.t0_ctrl_b;
            `TMR_A_T0_CMP_A:  s_d.rdata = s_q.t0_cmp_a;
            `TMR_A_T0_CMP_B:  s_d.rdata = s_q.t0_cmp_b;
            `TMR_A_T0_CNT:    s_d.rdata = t0_count;
            `TMR_A_W_CTRL_A:  s_d.rdata = s_q.w_ctrl_a;
            `TMR_A_W_CTRL_B:  s_d.rdata = s_q.w_ctrl_b;
            `TMR_A_W_CMPA_L:  s_d.rdata = s_q.w_cmp_a_buf[7:0];
            `TMR_A_W_CMPA_H:  s_d.rdata = s_q.w_cmp_a_buf[15:8];
            `TMR_A_W_CMPB_L:  s_d.rdata = s_q.w_cmp_b_buf[7:0];
            `TMR_A_W_CMPB_H:  s_d.rdata = s_q.w_cmp_b_buf[15:8];
            `TMR_A_W_CNT_L: begin
               s_d.rdata = w_count[7:0];
               s_d.temp  = w_count[15:8];
            end
            `TMR_A_W_CAP_L: begin
               s_d.rdata = s_q.w_capture[7:0];
               s_d.temp  = s_q.w_capture[15:8];
            end
            `TMR_A_W_CNT_H,
            `TMR_A_W_CAP_H:   s_d.rdata = s_q.temp;
            default:          s_d.rdata = `TMR_RST_BYTE;
         endcase
      end

      // Flags: set beats clear
      flag_set                   = '0;
      flag_set[`TMR_B_T0_CMPA]   = t0_ma;
      flag_set[`TMR_B_T0_OVF]    = t0_ovf_ev;
      flag_set[`TMR_B_T0_CMPB]   = t0_mb;
      flag_set[`TMR_B_W_CAP]     = cap_edge;
      flag_set[`TMR_B_W_CMPA]    = w_ma;
      flag_set[`TMR_B_W_CMPB]    = w_mb;
      flag_set[`TMR_B_W_OVF]     = w_ovf_ev;
      flag_clr                   = vector_taken;
      if (io_wr && io_addr == `TMR_A_FLAGS) begin
         flag_clr = flag_clr | io_wdata;
      end
      s_d.flags = ((s_q.flags & ~flag_clr) | flag_set) & `TMR_FLAGS_USED;

      // Waveform outputs
      s_d.wave_a = tmr_pkg::wave_next(s_q.wave_a, s_q.w_ctrl_a[7:6], w_slope, w_ma, w_top_ev,
                                      w_down, w_top_sel == tmr_pkg::TS_CMPA);
      s_d.wave_b = tmr_pkg::wave_next(s_q.wave_b, s_q.w_ctrl_a[5:4], w_slope, w_mb, w_top_ev,
                                      w_down, 1'b0);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Mask enables of the wide compares sit on the swapped bits
   always_comb begin
      mask_by_flag                = s_q.mask;
      mask_by_flag[`TMR_B_W_CMPA] = s_q.mask[`TMR_M_W_CMPA];
      mask_by_flag[`TMR_B_W_CMPB] = s_q.mask[`TMR_M_W_CMPB];
   end

   assign irq_req         = s_q.flags & mask_by_flag & {8{global_irq_en}};
   assign io_rdata        = s_q.rdata;
   assign wide_wave_out_a = s_q.wave_a;
   assign wide_wave_out_b = s_q.wave_b;

endmodule

// file: test/tmr_core_checker.sv
`timescale 1ns/1ps
module tmr_core_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [5:0] io_addr,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       global_irq_en,
   input wire logic [7:0] vector_taken,
   input wire logic [7:0] irq_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence flag_rd;
      io_rd && io_addr == 6'h39;
   endsequence
   sequence zero_wr;
      io_wr && io_addr == 6'h39 && io_wdata == 8'h00 && vector_taken == 8'h00;
   endsequence
   chk_gie_gate: assert property (!global_irq_en |-> irq_req == 8'h00)
      else $error("Request without global enable");
   chk_rsv_zero: assert property (flag_rd |=> io_rdata[4] == 1'b0)
      else $error("Reserved flag bit reads one");
   chk_rd_hold: assert property (!io_rd |=> $stable(io_rdata))
      else $error("Read data moved without a read");
   chk_unmapped: assert property (io_rd && io_addr == 6'h00 |=> io_rdata == 8'h00)
      else $error("Unmapped read not zero");
   chk_flag_vis: assert property (flag_rd |=> (io_rdata & $past(irq_req)) == $past(irq_req))
      else $error("Pending request missing from flags");
   chk_zero_wr: assert property (zero_wr |=> !global_irq_en ||
      (irq_req & $past(irq_req)) == $past(irq_req)) else $error("Zero write cleared a flag");
   chk_flags_keep: assert property (!io_wr && vector_taken == 8'h00 |=>
      !global_irq_en || (irq_req & $past(irq_req)) == $past(irq_req))
      else $error("Flag cleared without a clear");
   chk_mask_off: assert property (io_wr && io_addr == 6'h3a && io_wdata == 8'h00 |=>
      irq_req == 8'h00) else $error("Request with mask cleared");
endmodule
bind tmr_core tmr_core_checker tmr_core_checker_inst (.clk, .rst, .io_addr, .io_wr, .io_rd,
   .io_wdata, .io_rdata, .global_irq_en, .vector_taken, .irq_req);

// file: test/tmr_cpu_model.sv
`timescale 1ns/1ps
module tmr_cpu_model (
   input  wire logic       clk,
   output logic      [5:0] io_addr,
   output logic            io_wr,
   output logic            io_rd,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      io_wdata <= ~d; // Released data must not keep showing the last value
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1 d = io_rdata;
   endtask
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      wr(a + 6'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask
   task automatic rd16(input logic [5:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 6'h01, v[15:8]);
   endtask
endmodule

// file: test/tmr_core_tb.sv
`timescale 1ns/1ps
module tmr_core_tb;
   logic        clk, rst, io_wr, io_rd, global_irq_en, cap_pin, wave_a, wave_b;
   logic [5:0]  io_addr;
   logic [7:0]  io_wdata, io_rdata, vector_taken, irq_req, rd_v, exp_flags;
   logic [15:0] w16;
   logic [31:0] seed;
   int          errors, check_count, cycles;
   tmr_core tmr_core_inst (.clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
      .global_irq_en, .vector_taken, .irq_req, .t0_ext_clock_pin(1'b0),
      .wide_ext_clock_pin(1'b0), .wide_capture_pin(cap_pin), .acmp_out(1'b0),
      .acmp_capture_sel(1'b0), .wide_wave_out_a(wave_a), .wide_wave_out_b(wave_b));
   tmr_cpu_model cpu (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard, well above the length of the sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      global_irq_en = 1'b0;
      vector_taken = 8'h00;
      cap_pin = 1'b0;
      seed = 32'hc767a87a;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         cpu.rd(i == 0 ? 6'h39 : i == 1 ? 6'h3a : 6'h00, rd_v);
         cmp8(rd_v, 8'h00);
      end
      cpu.wr(6'h18, 8'h10);
      cpu.wr(6'h17, 8'h20);
      for (int i = 0; i < 2; i++) begin
         cpu.wr(6'h1a, 8'h01);
         repeat (i == 0 ? 60 : 250) @(posedge clk);
         cpu.wr(6'h1a, 8'h00);
         exp_flags = i == 0 ? 8'h05 : 8'h07;
         cpu.rd(6'h39, rd_v);
         cmp8(rd_v, exp_flags);
      end
      cpu.wr(6'h3a, 8'h07);
      #1 cmp8(irq_req, 8'h00);
      @(posedge clk) global_irq_en <= 1'b1;
      #1 cmp8(irq_req, exp_flags);
      seed = xs(seed);
      cpu.wr(6'h3a, seed[7:0]);
      #1 cmp8(irq_req, exp_flags & seed[7:0]);
      cpu.wr(6'h3a, 8'h07);
      @(posedge clk) vector_taken <= 8'h01;
      @(posedge clk) vector_taken <= 8'h00;
      exp_flags = 8'h06;
      #1 cmp8(irq_req, exp_flags);
      seed = xs(seed);
      cpu.wr(6'h39, seed[7:0] & 8'hfb);
      exp_flags = exp_flags & ~(seed[7:0] & 8'hfb);
      for (int i = 0; i < 2; i++) begin
         cpu.rd(6'h39, rd_v);
         cmp8(rd_v, exp_flags);
         cpu.wr(6'h39, 8'h00);
      end
      cpu.wr16(6'h2c, seed[31:16]);
      repeat (20) @(posedge clk);
      cpu.rd16(6'h2c, w16);
      cmp8(w16[15:8], seed[31:24]);
      cmp8(w16[7:0], seed[23:16]);
      cpu.wr(6'h2f, seed[15:8]);
      cpu.wr(6'h2e, seed[23:16] & 8'hd8);
      cpu.rd(6'h2f, rd_v);
      cmp8(rd_v, seed[15:8] & 8'hf3);
      cpu.rd(6'h2e, rd_v);
      cmp8(rd_v, seed[23:16] & 8'hd8);
      cpu.wr(6'h2f, 8'h00);
      cpu.wr16(6'h2c, 16'h0100);
      cpu.wr(6'h2e, 8'h41);
      @(posedge clk) cap_pin <= 1'b1;
      repeat (4) @(posedge clk);
      cpu.rd(6'h39, rd_v);
      cmp8(rd_v, exp_flags | 8'h08);
      cpu.rd16(6'h26, w16);
      cmp8(w16[15:8], 8'h01);
      cmp8(w16[7:0], 8'h02);
      cpu.wr16(6'h2a, 16'h0180);
      cpu.wr(6'h2f, 8'h40);
      repeat (200) @(posedge clk);
      #1 cmp8({7'h00, wave_a}, 8'h01);
      cmp8({7'h00, wave_b}, 8'h00);
      cpu.rd(6'h39, rd_v);
      cmp8(rd_v, exp_flags | 8'h28);
      cpu.wr(6'h3a, 8'h00);
      #1 cmp8(irq_req, 8'h00);
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule
